//--- verilog/adc_wdg_regs.sv
// Converter register bank with per-entry analog watchdog behind AXI4-Lite
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module adc_wdg_regs #(
  parameter int unsigned BUF_ENTRIES   = 10,
  parameter bit          HIGH_CHANNELS = 1'b1,
  parameter bit          REDUCED       = 1'b0
) (
  input  wire logic                         clock_i,
  input  wire logic                         rst_i,
  input  wire logic                         ce_i,
  input  wire logic [11:0]                  s_axi_awaddr_i,
  input  wire logic                         s_axi_awvalid_i,
  output logic                              s_axi_awready_o,
  input  wire logic [31:0]                  s_axi_wdata_i,
  input  wire logic [3:0]                   s_axi_wstrb_i,
  input  wire logic                         s_axi_wvalid_i,
  output logic                              s_axi_wready_o,
  output logic [1:0]                        s_axi_bresp_o,
  output logic                              s_axi_bvalid_o,
  input  wire logic                         s_axi_bready_i,
  input  wire logic [11:0]                  s_axi_araddr_i,
  input  wire logic                         s_axi_arvalid_i,
  output logic                              s_axi_arready_o,
  output logic [31:0]                       s_axi_rdata_o,
  output logic [1:0]                        s_axi_rresp_o,
  output logic                              s_axi_rvalid_o,
  input  wire logic                         s_axi_rready_i,
  input  wire adc_wdg_pkg::conv_result_type conv_result_i,
  input  wire logic                         overrun_i,
  output adc_wdg_pkg::ctrl_type             ctrl_o,
  output logic                              irq_o
);
  typedef struct packed {
    logic                 aw_held;
    logic [11:0]          awaddr;
    logic                 w_held;
    logic [7:0]           wdata;
    logic                 wstrb0;
    logic                 awready;
    logic                 wready;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 arready;
    logic                 rvalid;
    logic [7:0]           rdata;
    logic [1:0]           rresp;
    logic [7:0]           csr;
    logic [7:0]           cr1;
    logic [7:0]           cr2;
    logic [7:0]           cr3;
    logic [15:0]          tdis;
    logic [9:0]           upper_limit;
    logic [9:0]           lower_limit;
    logic [9:0]           result;
    logic [9:0][9:0]      buffer;
    logic [9:0]           watchdog_entry_enable;
    adc_wdg_pkg::ctrl_type ctrl;
  } main_state_type;

  main_state_type s_r;
  main_state_type s_nxt;

  logic       wr_go;
  logic [1:0] wr_region;
  logic [5:0] wr_idx;
  logic       wr_ok;
  logic       wr_en;
  logic [7:0] wd;
  logic [1:0] rd_region;
  logic [5:0] rd_idx;
  logic       rd_ok;
  logic [7:0] rd_val;
  logic       buffered;
  logic       store;
  logic [9:0] entry_on;
  logic [9:0] arm;
  logic [9:0] clear;
  logic [9:0] entry_event;
  logic [9:0] flags;
  logic [2:0] irq_event;
  logic [2:0] irq_status;
  logic [2:0] irq_enable;
  logic       irq_en_wr;
  logic       irq_clr_wr;

  function automatic logic [1:0] region_of(input logic [11:0] a);
    logic [1:0] r;
    r = adc_wdg_pkg::REG_NONE;
    if (a[11:8] == adc_wdg_pkg::BUF_BASE[11:8] && a[7] == 1'b0) begin
      r = adc_wdg_pkg::REG_BUF;
    end else if (a[11:7] == adc_wdg_pkg::CTRL_BASE[11:7]) begin
      r = adc_wdg_pkg::REG_CTRL;
    end else if (a[11:7] == adc_wdg_pkg::IRQ_BASE[11:7]) begin
      r = adc_wdg_pkg::REG_IRQ;
    end
    return r;
  endfunction

  // Entry is wired only when the buffer and channel options provide it
  function automatic logic entry_present(input int unsigned i);
    return !REDUCED && (i < BUF_ENTRIES) && (i < 8 || HIGH_CHANNELS);
  endfunction

  // Mapped offsets; reserved registers stay mapped but read zero
  function automatic logic mapped(input logic [1:0] r, input logic [5:0] i);
    logic m;
    m = 1'b0;
    case (r)
      adc_wdg_pkg::REG_BUF: begin
        m = !REDUCED && i <= adc_wdg_pkg::BUF_LAST;
      end
      adc_wdg_pkg::REG_CTRL: begin
        m = i <= (REDUCED ? adc_wdg_pkg::TDL_IDX : adc_wdg_pkg::ENL_IDX);
      end
      adc_wdg_pkg::REG_IRQ: begin
        m = i <= adc_wdg_pkg::IRQ_CLR_IDX;
      end
      default: begin
        m = 1'b0;
      end
    endcase
    return m;
  endfunction

  assign wr_go     = s_r.aw_held & s_r.w_held & ~s_r.bvalid;
  assign wr_region = region_of(s_r.awaddr);
  // Bit 7 is dropped so the interrupt block at 0x180 starts at index zero
  assign wr_idx    = {1'b0, s_r.awaddr[6:2]};
  assign wr_ok     = mapped(wr_region, wr_idx);
  assign wr_en     = wr_go & wr_ok & s_r.wstrb0;
  assign wd        = s_r.wdata;
  assign rd_region = region_of(s_axi_araddr_i);
  assign rd_idx    = {1'b0, s_axi_araddr_i[6:2]};
  assign rd_ok     = mapped(rd_region, rd_idx);

  assign irq_en_wr  = wr_en && wr_region == adc_wdg_pkg::REG_IRQ
                      && wr_idx == adc_wdg_pkg::IRQ_EN_IDX;
  assign irq_clr_wr = wr_en && wr_region == adc_wdg_pkg::REG_IRQ
                      && wr_idx == adc_wdg_pkg::IRQ_CLR_IDX;

  assign buffered = (s_r.cr3[adc_wdg_pkg::CR3_BUFFER_ENABLE] & s_r.cr1[adc_wdg_pkg::CR1_CONTINUOUS_CONVERSION])
                    | s_r.cr2[adc_wdg_pkg::CR2_SCAN];
  assign store    = conv_result_i.valid;

  // Software clear writes a zero; a one leaves the flag alone
  always_comb begin
    clear = 10'h000;
    if (wr_en && wr_region == adc_wdg_pkg::REG_CTRL) begin
      if (wr_idx == adc_wdg_pkg::FLH_IDX) begin
        clear[9:8] = ~wd[1:0];
      end
      if (wr_idx == adc_wdg_pkg::FLL_IDX) begin
        clear[7:0] = ~wd;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < adc_wdg_pkg::ENTRIES; g++) begin : gen_entry
      assign entry_on[g] = entry_present(g);
      assign arm[g] = entry_on[g] & store & buffered
                      & (conv_result_i.entry == 4'(g))
                      & s_r.watchdog_entry_enable[g];
      wdg_entry u_entry (
        .clock_i       (clock_i),
        .rst_i         (rst_i),
        .ce_i          (ce_i),
        .arm_i         (arm[g]),
        .data_i        (conv_result_i.data),
        .upper_limit_i (s_r.upper_limit),
        .lower_limit_i (s_r.lower_limit),
        .clear_i       (clear[g]),
        .event_o       (entry_event[g]),
        .flag_o        (flags[g])
      );
    end
  endgenerate

  assign irq_event[adc_wdg_pkg::EV_EOC] = store;
  assign irq_event[adc_wdg_pkg::EV_AWD] = |entry_event;
  assign irq_event[adc_wdg_pkg::EV_OVR] = overrun_i;

  irq_bank u_irq (
    .clock_i  (clock_i),
    .rst_i    (rst_i),
    .ce_i     (ce_i),
    .event_i  (irq_event),
    .en_wr_i  (irq_en_wr),
    .clr_wr_i (irq_clr_wr),
    .wdata_i  (wd[2:0]),
    .status_o (irq_status),
    .enable_o (irq_enable),
    .irq_o    (irq_o)
  );

  // Read mux; reserved bits and reserved registers return zero
  always_comb begin
    rd_val = 8'h00;
    case (rd_region)
      adc_wdg_pkg::REG_BUF: begin
        if (rd_idx <= adc_wdg_pkg::BUF_LAST
            && (rd_idx < adc_wdg_pkg::BUF_PAIR8 || BUF_ENTRIES > 8)) begin
          rd_val = rd_idx[0] ? s_r.buffer[rd_idx[4:1]][7:0]
                             : {6'h00, s_r.buffer[rd_idx[4:1]][9:8]};
        end
      end
      adc_wdg_pkg::REG_CTRL: begin
        case (rd_idx)
          adc_wdg_pkg::CSR_IDX: rd_val = s_r.csr;
          adc_wdg_pkg::CR1_IDX: rd_val = s_r.cr1;
          adc_wdg_pkg::CR2_IDX: rd_val = s_r.cr2;
          adc_wdg_pkg::CR3_IDX: rd_val = s_r.cr3;
          adc_wdg_pkg::DRH_IDX: begin
            rd_val = s_r.cr2[adc_wdg_pkg::CR2_ALIGN] ? {6'h00, s_r.result[9:8]}
                                                     : s_r.result[9:2];
          end
          adc_wdg_pkg::DRL_IDX: begin
            rd_val = s_r.cr2[adc_wdg_pkg::CR2_ALIGN] ? s_r.result[7:0]
                                                     : {s_r.result[1:0], 6'h00};
          end
          adc_wdg_pkg::TDH_IDX: rd_val = HIGH_CHANNELS ? s_r.tdis[15:8] : 8'h00;
          adc_wdg_pkg::TDL_IDX: rd_val = s_r.tdis[7:0];
          adc_wdg_pkg::UPH_IDX: rd_val = s_r.upper_limit[9:2];
          adc_wdg_pkg::UPL_IDX: rd_val = {6'h00, s_r.upper_limit[1:0]};
          adc_wdg_pkg::LOH_IDX: rd_val = s_r.lower_limit[9:2];
          adc_wdg_pkg::LOL_IDX: rd_val = {6'h00, s_r.lower_limit[1:0]};
          adc_wdg_pkg::FLH_IDX: rd_val = {6'h00, flags[9:8]};
          adc_wdg_pkg::FLL_IDX: rd_val = flags[7:0];
          adc_wdg_pkg::ENH_IDX: rd_val = {6'h00, s_r.watchdog_entry_enable[9:8]};
          adc_wdg_pkg::ENL_IDX: rd_val = s_r.watchdog_entry_enable[7:0];
          default: rd_val = 8'h00;
        endcase
      end
      adc_wdg_pkg::REG_IRQ: begin
        if (rd_idx == adc_wdg_pkg::IRQ_STAT_IDX) begin
          rd_val = {5'h00, irq_status};
        end else if (rd_idx == adc_wdg_pkg::IRQ_EN_IDX) begin
          rd_val = {5'h00, irq_enable};
        end
      end
      default: rd_val = 8'h00;
    endcase
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.ctrl.start = 1'b0;
    // Address and data are captured independently, in either order
    if (s_axi_awvalid_i && s_r.awready) begin
      s_nxt.aw_held = 1'b1;
      s_nxt.awaddr  = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_r.wready) begin
      s_nxt.w_held = 1'b1;
      s_nxt.wdata  = s_axi_wdata_i[7:0];
      s_nxt.wstrb0 = s_axi_wstrb_i[0];
    end
    if (wr_go) begin
      s_nxt.aw_held = 1'b0;
      s_nxt.w_held  = 1'b0;
      s_nxt.bvalid  = 1'b1;
      s_nxt.bresp   = wr_ok ? adc_wdg_pkg::RESP_OKAY : adc_wdg_pkg::RESP_SLVERR;
    end else if (s_r.bvalid && s_axi_bready_i) begin
      s_nxt.bvalid = 1'b0;
    end
    if (wr_en && wr_region == adc_wdg_pkg::REG_CTRL) begin
      case (wr_idx)
        adc_wdg_pkg::CSR_IDX: begin
          s_nxt.csr = (s_r.csr & ~adc_wdg_pkg::CSR_RW_MASK & wd)
                      | (wd & adc_wdg_pkg::CSR_RW_MASK);
        end
        adc_wdg_pkg::CR1_IDX: begin
          s_nxt.cr1 = wd & adc_wdg_pkg::CR1_MASK;
          // Start only when power is already on and nothing else changes
          s_nxt.ctrl.start = s_r.cr1[adc_wdg_pkg::CR1_CONVERTER_POWER_ON]
                             && (wd & adc_wdg_pkg::CR1_MASK) == s_r.cr1;
        end
        adc_wdg_pkg::CR2_IDX: begin
          s_nxt.cr2 = wd & (REDUCED ? adc_wdg_pkg::CR2_RED_MASK : adc_wdg_pkg::CR2_MASK);
        end
        adc_wdg_pkg::CR3_IDX: begin
          s_nxt.cr3 = (s_r.cr3 & ~adc_wdg_pkg::CR3_RW_MASK & wd)
                      | (wd & adc_wdg_pkg::CR3_RW_MASK);
        end
        adc_wdg_pkg::TDH_IDX: begin
          if (HIGH_CHANNELS) begin
            s_nxt.tdis[15:8] = wd;
          end
        end
        adc_wdg_pkg::TDL_IDX: s_nxt.tdis[7:0] = wd;
        adc_wdg_pkg::UPH_IDX: s_nxt.upper_limit[9:2] = wd;
        adc_wdg_pkg::UPL_IDX: s_nxt.upper_limit[1:0] = wd[1:0];
        adc_wdg_pkg::LOH_IDX: s_nxt.lower_limit[9:2] = wd;
        adc_wdg_pkg::LOL_IDX: s_nxt.lower_limit[1:0] = wd[1:0];
        adc_wdg_pkg::ENH_IDX: begin
          s_nxt.watchdog_entry_enable[9:8] = wd[1:0] & entry_on[9:8];
        end
        adc_wdg_pkg::ENL_IDX: begin
          s_nxt.watchdog_entry_enable[7:0] = wd & entry_on[7:0];
        end
        default: begin
        end
      endcase
    end
    // Hardware status sets land after software writes so they win
    if (store) begin
      s_nxt.csr[adc_wdg_pkg::CSR_EOC] = 1'b1;
      if (buffered) begin
        if (conv_result_i.entry < 4'(BUF_ENTRIES) && !REDUCED) begin
          s_nxt.buffer[conv_result_i.entry] = conv_result_i.data;
        end
      end else begin
        s_nxt.result = conv_result_i.data;
      end
    end
    if (|entry_event) begin
      s_nxt.csr[adc_wdg_pkg::CSR_AWD] = 1'b1;
    end
    if (overrun_i) begin
      s_nxt.cr3[adc_wdg_pkg::CR3_OVR] = 1'b1;
    end
    // Read channel: one outstanding read, answered the cycle after acceptance
    if (s_axi_arvalid_i && s_r.arready) begin
      s_nxt.arready = 1'b0;
      s_nxt.rvalid  = 1'b1;
      s_nxt.rdata   = rd_val;
      s_nxt.rresp   = rd_ok ? adc_wdg_pkg::RESP_OKAY : adc_wdg_pkg::RESP_SLVERR;
    end else if (s_r.rvalid && s_axi_rready_i) begin
      s_nxt.rvalid  = 1'b0;
      s_nxt.arready = 1'b1;
    end
    s_nxt.awready = ~s_nxt.aw_held & ~s_nxt.bvalid;
    s_nxt.wready  = ~s_nxt.w_held & ~s_nxt.bvalid;
    s_nxt.ctrl.converter_power_on         = s_nxt.cr1[adc_wdg_pkg::CR1_CONVERTER_POWER_ON];
    s_nxt.ctrl.continuous_conversion      = s_nxt.cr1[adc_wdg_pkg::CR1_CONTINUOUS_CONVERSION];
    s_nxt.ctrl.prescaler_select           = s_nxt.cr1[6:4];
    s_nxt.ctrl.external_trigger_enable    = s_nxt.cr2[6];
    s_nxt.ctrl.external_event_select      = s_nxt.cr2[5:4];
    s_nxt.ctrl.align_right                = s_nxt.cr2[adc_wdg_pkg::CR2_ALIGN];
    s_nxt.ctrl.scan                       = s_nxt.cr2[adc_wdg_pkg::CR2_SCAN];
    s_nxt.ctrl.buffer_enable              = s_nxt.cr3[adc_wdg_pkg::CR3_BUFFER_ENABLE];
    s_nxt.ctrl.channel                    = s_nxt.csr[3:0];
    s_nxt.ctrl.watchdog_irq_enable        = s_nxt.csr[4];
    s_nxt.ctrl.conversion_done_irq_enable = s_nxt.csr[5];
    s_nxt.ctrl.input_trigger_disable      = s_nxt.tdis;
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      s_r             <= '0;
      s_r.upper_limit <= adc_wdg_pkg::UPPER_RST;
      s_r.lower_limit <= adc_wdg_pkg::LOWER_RST;
      s_r.awready     <= 1'b1;
      s_r.wready      <= 1'b1;
      s_r.arready     <= 1'b1;
    end else if (ce_i) begin
      s_r <= s_nxt;
    end
  end

  assign s_axi_awready_o = s_r.awready;
  assign s_axi_wready_o  = s_r.wready;
  assign s_axi_bvalid_o  = s_r.bvalid;
  assign s_axi_bresp_o   = s_r.bresp;
  assign s_axi_arready_o = s_r.arready;
  assign s_axi_rvalid_o  = s_r.rvalid;
  assign s_axi_rdata_o   = {24'h000000, s_r.rdata};
  assign s_axi_rresp_o   = s_r.rresp;
  assign ctrl_o          = s_r.ctrl;
endmodule
`default_nettype wire

//--- verilog/adc_wdg_pkg.sv
// Constants and carrier types for the converter register bank and watchdog
// Function
// - Ten sticky flags at 0x0C[1:0] and 0x0D
// - Flag 1 means event seen for entry
// - Flags work per entry in buffered/scan modes
// - Ten writable enables arm each buffer entry
// - Enables at 0x0E[1:0] and 0x0F
// - Pairs 0x10-0x13 reserved with eight entries
// - High trigger/flag/enable reserved without channels 8-9
// - Reduced instance map ends at 0x07
// - Buffered mode needs buffer and continuous set, or scan set alone
// - Ten-bit limits split as 9:2 and 1:0
package adc_wdg_pkg;
  localparam int unsigned   ENTRIES      = 10;
  localparam int unsigned   DATA_W       = 10;
  localparam int unsigned   ADDR_W       = 12;
  localparam int unsigned   IRQ_N        = 3;
  // Address regions; register byte address is region base plus index times four
  localparam logic [1:0]    REG_BUF      = 2'h0;
  localparam logic [1:0]    REG_CTRL     = 2'h1;
  localparam logic [1:0]    REG_IRQ      = 2'h2;
  localparam logic [1:0]    REG_NONE     = 2'h3;
  localparam logic [11:0]   BUF_BASE     = 12'h000;
  localparam logic [11:0]   CTRL_BASE    = 12'h100;
  localparam logic [11:0]   IRQ_BASE     = 12'h180;
  localparam logic [5:0]    BUF_LAST     = 6'h13;
  localparam logic [5:0]    BUF_PAIR8    = 6'h10;
  localparam logic [5:0]    CSR_IDX      = 6'h00;
  localparam logic [5:0]    CR1_IDX      = 6'h01;
  localparam logic [5:0]    CR2_IDX      = 6'h02;
  localparam logic [5:0]    CR3_IDX      = 6'h03;
  localparam logic [5:0]    DRH_IDX      = 6'h04;
  localparam logic [5:0]    DRL_IDX      = 6'h05;
  localparam logic [5:0]    TDH_IDX      = 6'h06;
  localparam logic [5:0]    TDL_IDX      = 6'h07;
  localparam logic [5:0]    UPH_IDX      = 6'h08;
  localparam logic [5:0]    UPL_IDX      = 6'h09;
  localparam logic [5:0]    LOH_IDX      = 6'h0A;
  localparam logic [5:0]    LOL_IDX      = 6'h0B;
  localparam logic [5:0]    FLH_IDX      = 6'h0C;
  localparam logic [5:0]    FLL_IDX      = 6'h0D;
  localparam logic [5:0]    ENH_IDX      = 6'h0E;
  localparam logic [5:0]    ENL_IDX      = 6'h0F;
  localparam logic [5:0]    IRQ_STAT_IDX = 6'h00;
  localparam logic [5:0]    IRQ_EN_IDX   = 6'h01;
  localparam logic [5:0]    IRQ_CLR_IDX  = 6'h02;
  // Field positions
  localparam int unsigned   CSR_EOC      = 7;
  localparam int unsigned   CSR_AWD      = 6;
  localparam int unsigned   CR1_CONVERTER_POWER_ON     = 0;
  localparam int unsigned   CR1_CONTINUOUS_CONVERSION     = 1;
  localparam int unsigned   CR2_SCAN     = 1;
  localparam int unsigned   CR2_ALIGN    = 3;
  localparam int unsigned   CR3_BUFFER_ENABLE     = 7;
  localparam int unsigned   CR3_OVR      = 6;
  localparam logic [7:0]    CSR_RW_MASK  = 8'h3F;
  localparam logic [7:0]    CR1_MASK     = 8'h73;
  localparam logic [7:0]    CR2_MASK     = 8'h7A;
  localparam logic [7:0]    CR2_RED_MASK = 8'h78;
  localparam logic [7:0]    CR3_RW_MASK  = 8'h80;
  localparam logic [7:0]    LSB2_MASK    = 8'h03;
  localparam int unsigned   EV_EOC       = 0;
  localparam int unsigned   EV_AWD       = 1;
  localparam int unsigned   EV_OVR       = 2;
  // Reset values and bus response codes
  localparam logic [7:0]    REG_RST      = 8'h00;
  localparam logic [9:0]    UPPER_RST    = 10'h3FF;
  localparam logic [9:0]    LOWER_RST    = 10'h000;
  localparam logic [1:0]    RESP_OKAY    = 2'h0;
  localparam logic [1:0]    RESP_SLVERR  = 2'h2;

  typedef struct packed {
    logic       valid;
    logic [3:0] entry;
    logic [9:0] data;
  } conv_result_type;

  typedef struct packed {
    logic        converter_power_on;
    logic        start;
    logic        continuous_conversion;
    logic [2:0]  prescaler_select;
    logic        external_trigger_enable;
    logic [1:0]  external_event_select;
    logic        align_right;
    logic        scan;
    logic        buffer_enable;
    logic [3:0]  channel;
    logic        conversion_done_irq_enable;
    logic        watchdog_irq_enable;
    logic [15:0] input_trigger_disable;
  } ctrl_type;
endpackage

//--- verilog/wdg_entry.sv
// One watchdog entry: window compare and sticky event flag
`timescale 1ns/100ps
`default_nettype none
module wdg_entry (
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  input  wire logic       arm_i,
  input  wire logic [9:0] data_i,
  input  wire logic [9:0] upper_limit_i,
  input  wire logic [9:0] lower_limit_i,
  input  wire logic       clear_i,
  output logic            event_o,
  output logic            flag_o
);
  typedef struct packed {
    logic watchdog_event_flag;
  } entry_state_type;

  entry_state_type s_r;
  entry_state_type s_nxt;

  assign event_o = arm_i & ((data_i > upper_limit_i) | (data_i < lower_limit_i));
  assign flag_o  = s_r.watchdog_event_flag;

  always_comb begin
    s_nxt = s_r;
    s_nxt.watchdog_event_flag = event_o | (s_r.watchdog_event_flag & ~clear_i);
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else if (ce_i) begin
      s_r <= s_nxt;
    end
  end
endmodule
`default_nettype wire

//--- verilog/irq_bank.sv
// Sticky interrupt status, enable and write-one-to-clear
`timescale 1ns/100ps
`default_nettype none
module irq_bank (
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  input  wire logic [2:0] event_i,
  input  wire logic       en_wr_i,
  input  wire logic       clr_wr_i,
  input  wire logic [2:0] wdata_i,
  output logic      [2:0] status_o,
  output logic      [2:0] enable_o,
  output logic            irq_o
);
  typedef struct packed {
    logic [2:0] status;
    logic [2:0] enable;
    logic       irq;
  } irq_state_type;

  irq_state_type s_r;
  irq_state_type s_nxt;

  assign status_o = s_r.status;
  assign enable_o = s_r.enable;
  assign irq_o    = s_r.irq;

  always_comb begin
    s_nxt = s_r;
    // Set beats a clear in the same cycle so no event slips past
    s_nxt.status = event_i | (s_r.status & ~(clr_wr_i ? wdata_i : 3'h0));
    if (en_wr_i) begin
      s_nxt.enable = wdata_i;
    end
    s_nxt.irq = |(s_nxt.status & s_nxt.enable);
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else if (ce_i) begin
      s_r <= s_nxt;
    end
  end
endmodule
`default_nettype wire

//--- verification/adc_wdg_regs_sva.sv
// Bus handshake and read data width checks for the converter register bank
`timescale 1ns/100ps
`default_nettype none
module adc_wdg_regs_sva (
  input wire logic        clock_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i,
  input wire logic [31:0] s_axi_rdata_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i || !ce_i);
  wr_refused_a: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write taken while answer waits");
  wr_answer_a: assert property (s_axi_awready_o && s_axi_awvalid_i && s_axi_wvalid_i
    && s_axi_wready_o |=> !s_axi_bvalid_o ##1 s_axi_bvalid_o) else $error("write answer late");
  b_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
    else $error("write answer dropped");
  wr_release_a: assert property (s_axi_bvalid_o && s_axi_bready_i
    |=> !s_axi_bvalid_o && s_axi_awready_o && s_axi_wready_o) else $error("write not freed");
  rd_answer_a: assert property (s_axi_arvalid_i && s_axi_arready_o
    |=> s_axi_rvalid_o && !s_axi_arready_o) else $error("read answer late");
  r_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i
    |=> s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("read answer changed");
  rd_release_a: assert property (s_axi_rvalid_o && s_axi_rready_i
    |=> !s_axi_rvalid_o && s_axi_arready_o) else $error("read not freed");
  byte_wide_a: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h000000)
    else $error("read data above byte");
endmodule
bind adc_wdg_regs adc_wdg_regs_sva i_adc_wdg_regs_sva (.*);
`default_nettype wire

//--- verification/core_model.sv
// Conversion core stand-in that hands results to the register bank
`timescale 1ns/100ps
`default_nettype none
module core_model (
  input  wire logic                    clock_i,
  output adc_wdg_pkg::conv_result_type result_o
);
  initial result_o = '0;
  task automatic send(input logic [3:0] e, input logic [9:0] d);
    @(posedge clock_i);
    result_o <= '{1'h1, e, d}; // One-cycle pulse, as the core gives one per result
    @(posedge clock_i);
    result_o <= '0;
  endtask
endmodule
`default_nettype wire

//--- verification/adc_wdg_regs_bench.sv
// Self-checking bench for the converter register bank and watchdog
`timescale 1ns/100ps
`default_nettype none
`define CHECK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module adc_wdg_regs_bench;
  logic        clock_i = 1'h0, rst_i = 1'h1, ce_i = 1'h1, overrun_i = 1'h0;
  logic        s_axi_awvalid_i = 1'h0, s_axi_wvalid_i = 1'h0, s_axi_bready_i = 1'h0;
  logic        s_axi_arvalid_i = 1'h0, s_axi_rready_i = 1'h0, irq_o, s_axi_awready_o;
  logic        s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [11:0] s_axi_awaddr_i = '0, s_axi_araddr_i = '0;
  logic [31:0] s_axi_wdata_i = '0, s_axi_rdata_o;
  logic [3:0]  s_axi_wstrb_i = 4'hF;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
  int          err_total = 0, comparisons = 0;
  adc_wdg_pkg::conv_result_type conv_result_i;
  adc_wdg_pkg::ctrl_type        ctrl_o;
  adc_wdg_regs i_adc_wdg_regs (.*);
  core_model i_core_model (.clock_i, .result_o(conv_result_i));
  always #2.5 clock_i = ~clock_i;
  initial begin
    repeat (4000) @(posedge clock_i); // Far above the roughly 130 cycles needed
    err_total++;
    conclude();
  end
  task automatic conclude();
    $display("mismatches %0d, comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clock_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= {24'h000000, d};
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 3'h7;
    do begin
      @(posedge clock_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'h0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'h0;
    end while (!s_axi_bvalid_o);
    s_axi_bready_i <= 1'h0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e,
                    input logic [1:0] r = adc_wdg_pkg::RESP_OKAY);
    @(posedge clock_i);
    s_axi_araddr_i <= a;
    {s_axi_arvalid_i, s_axi_rready_i} <= 2'h3;
    do begin
      @(posedge clock_i);
      if (s_axi_arready_o) s_axi_arvalid_i <= 1'h0;
    end while (!s_axi_rvalid_o);
    s_axi_rready_i <= 1'h0;
    `CHECK(s_axi_rdata_o[7:0], e)
    `CHECK(s_axi_rresp_o, r)
  endtask
  task automatic t_window();
    logic [19:0] setup [8] = '{20'h12080, 20'h12400, 20'h12840, 20'h12C00,
                               20'h13803, 20'h13CA5, 20'h10C80, 20'h10402};
    logic [13:0] hits [5] = '{14'h27FF, 14'h2200, 14'h1D00, 14'h08FF, 14'h07FF};
    rd(12'h130, 8'h00);
    rd(12'h124, 8'h03);
    rd(12'h1F0, 8'h00, adc_wdg_pkg::RESP_SLVERR);
    foreach (setup[i]) wr(setup[i][19:8], setup[i][7:0]);
    foreach (hits[i]) i_core_model.send(hits[i][13:10], hits[i][9:0]);
    rd(12'h13C, 8'hA5);
    rd(12'h130, 8'h02);
    rd(12'h134, 8'h04);
    rd(12'h048, 8'h03);
  endtask
  task automatic t_clear_scan();
    wr(12'h134, 8'hFB);
    wr(12'h130, 8'h01);
    rd(12'h134, 8'h00);
    wr(12'h10C, 8'h00);
    wr(12'h108, 8'h02);
    `CHECK(ctrl_o.scan, 1'h1)
    i_core_model.send(4'h5, 10'h000);
    i_core_model.send(4'h0, 10'h3FF);
    rd(12'h134, 8'h21);
  endtask
  task automatic t_irq();
    wr(12'h184, 8'h02);
    rd(12'h180, 8'h03);
    `CHECK(irq_o, 1'h1)
    wr(12'h184, 8'h00);
    rd(12'h184, 8'h00);
    `CHECK(irq_o, 1'h0)
    wr(12'h188, 8'h02);
    rd(12'h180, 8'h01);
    @(posedge clock_i) overrun_i <= 1'h1;
    @(posedge clock_i) overrun_i <= 1'h0;
    rd(12'h10C, 8'h40);
    rd(12'h180, 8'h05);
  endtask
  initial begin
    repeat (8) @(posedge clock_i);
    rst_i <= 1'h0;
    t_window();
    t_clear_scan();
    t_irq();
    conclude();
  end
endmodule
`default_nettype wire
